//--- design/lpl_link.sv
`timescale 1ns/1ps
// Overview of operation
// [RL1] At gigabit line speed, link clock runs at 62.5 MHz.
// [RL2] At 100 Mbps line speed, link clock runs at 50 MHz.
// [RL3] At 10 Mbps line speed, link clock runs at 5 MHz.
// [RL4] In power-down the link clock stops, held at zero.
// [RL5] Reset/sync held beyond one link clock cycle means reset request.
// [RL6] Partner holds reset/sync at least 500 us to guarantee reset.
// [RL7] Long reset/sync assertion wakes the device from power-down.
// [RL8] One-cycle reset/sync pulse aligns word framing, is not a reset.
// [RL9] Partner drives transmit lines synchronous to our link clock.
// [RL10] Transmit lines carry control and management data into device.
// [RL11] Receive lines carry control and management data to partner.
// [RL12] Indicators a,c follow word 18h; indicator b follows word 17h.
// [RL13] Test enable strap low for normal use, high enables test.
// [RL14] Count asserted reset/sync cycles per link clock edge; in power-down the code counts core cycles instead.
// [RL15] Gigabit traffic uses serial link; rest uses this parallel link.
module lpl_link
   import lpl_pkg::*;
#(
   parameter int RST_CYCLES = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Line state from media side
   input wire logic [1:0] line_speed,
   input wire logic power_down_req,
   input wire logic link_up,
   input wire logic activity,
   // Partner pins
   output logic link_clock_out,
   input wire logic reset_sync_line,
   input wire logic link_tx_bit2,
   input wire logic link_tx_bit1,
   input wire logic link_tx_bit0,
   output logic link_rx_bit2,
   output logic link_rx_bit1,
   output logic link_rx_bit0,
   // Received words toward the core
   output logic [WORD_W-1:0] rx_word,
   output logic rx_valid,
   input wire logic rx_ready,
   // Words to send to partner
   input wire logic [WORD_W-1:0] tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   // Nonvolatile load of indicator words
   input wire logic nvm_we,
   input wire logic [7:0] nvm_addr,
   input wire logic [15:0] nvm_data,
   // Indicators and status
   output logic indicator_a,
   output logic indicator_b,
   output logic indicator_c,
   output logic link_reset,
   output logic powered_down,
   output logic serial_path_sel,
   // Test strap
   input wire logic test_en,
   output logic test_mode
);
   ////////////////////////////////////////////////////////////////
   // Field of an indicator word
   function automatic logic led_eval(input logic [3:0] m,
                                     input logic lk, input logic ac,
                                     input logic g);
      case (m)
         LED_ON: return 1'b1;
         LED_LINK: return lk;
         LED_ACT: return lk & ac;
         LED_L1000: return lk & g;
         default: return 1'b0;
      endcase
   endfunction

   logic pd_q;
   logic [17:0] acc_q;
   logic [17:0] step_w;
   logic [18:0] acc_sum;
   logic lclk_q;
   logic [2:0] rs_s_q;
   logic [2:0] t2_q;
   logic [2:0] t1_q;
   logic [2:0] t0_q;
   logic [2:0] ts_q;
   logic lck_prev_q;
   logic lck_rise;
   logic [31:0] rcnt_q;
   logic [1:0] beat_q;
   logic [WORD_W-1:0] sh_q;
   logic [WORD_W-1:0] buf_q [2];
   logic [1:0] cnt_q;
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic word_done;
   logic [WORD_W-1:0] txs_q;
   logic [1:0] tbeat_q;
   logic [15:0] led_ac_q;
   logic [15:0] led_b_q;
   logic rs_now;
   logic sync_pend_q;
   logic frame_q;
   logic sync_take;

   ////////////////////////////////////////////////////////////////
   // Link clock rate per line speed, as a toggle step in kHz
   always_comb begin
      case (line_speed)
         SPD_1000: step_w = 18'(2 * LCLK_1000_KHZ); // RL1
         SPD_100: step_w = 18'(2 * LCLK_100_KHZ); // RL2
         default: step_w = 18'(2 * LCLK_10_KHZ); // RL3
      endcase
   end

   assign acc_sum = {1'b0, acc_q} + {1'b0, step_w};

   // Phase accumulator; gigabit needs 3.2 core cycles a period, so
   // periods of three and four cycles mix to give 62.5 MHz exactly
   always_ff @(posedge clk) begin
      if (rst || pd_q) begin
         acc_q <= 18'h0_0000;
         lclk_q <= 1'b0; // RL4
      end else if (acc_sum >= 19'(CLK_KHZ)) begin
         acc_q <= 18'(acc_sum - 19'(CLK_KHZ));
         lclk_q <= ~lclk_q;
      end else begin
         acc_q <= acc_sum[17:0];
      end
   end

   // Sample partner pins: three flops; reset/sync needs second and third both high
   always_ff @(posedge clk) begin
      if (rst) begin
         rs_s_q <= 3'h0;
         t2_q <= 3'h0;
         t1_q <= 3'h0;
         t0_q <= 3'h0;
         ts_q <= 3'h0;
      end else begin
         rs_s_q <= {rs_s_q[1:0], reset_sync_line};
         t2_q <= {t2_q[1:0], link_tx_bit2}; // RL9
         t1_q <= {t1_q[1:0], link_tx_bit1};
         t0_q <= {t0_q[1:0], link_tx_bit0};
         ts_q <= {ts_q[1:0], test_en};
      end
   end

   assign rs_now = rs_s_q[2] & rs_s_q[1];
   // Partner drives just after our rising edge, so we sample on the rise
   assign lck_rise = lclk_q & ~lck_prev_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         lck_prev_q <= 1'b0;
      end else begin
         lck_prev_q <= lclk_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Reset/sync length counter; in power-down the link clock is
   // stopped, so counting falls back to core cycles to allow wake
   always_ff @(posedge clk) begin
      if (rst || !rs_now) begin
         rcnt_q <= 32'h0000_0000;
      end else if ((lck_rise || pd_q) && rcnt_q != 32'hFFFF_FFFF) begin
         rcnt_q <= rcnt_q + 32'h0000_0001; // RL14
      end
   end

   // Reset request once held past one link cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         link_reset <= 1'b0;
      end else begin
         link_reset <= rcnt_q >= 32'(RST_CYCLES); // RL5
      end
   end

   // Sync pulse seen on one link edge; held until the next rise,
   // since at slow rates it has long gone by then
   always_ff @(posedge clk) begin
      if (rst || link_reset) begin
         sync_pend_q <= 1'b0;
      end else if (rs_now && rcnt_q == 32'h0000_0001) begin
         sync_pend_q <= 1'b1;
      end else if (lck_rise && !rs_now) begin
         sync_pend_q <= 1'b0; // RL8
      end
   end

   // Power state; a long assertion wakes the device
   always_ff @(posedge clk) begin
      if (rst) begin
         pd_q <= 1'b0;
      end else if (link_reset) begin
         pd_q <= 1'b0; // RL7
      end else if (power_down_req) begin
         pd_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   assign sync_take = lck_rise && sync_pend_q && !rs_now;

   // Word assembly from transmit lines; only a sync frames a word,
   // so idle beats between words never reach the buffer
   always_ff @(posedge clk) begin
      if (rst || link_reset) begin
         beat_q <= 2'h0;
         sh_q <= '0;
         frame_q <= 1'b0;
      end else if (lck_rise) begin
         sh_q <= {sh_q[WORD_W-4:0], t2_q[2], t1_q[2], t0_q[2]}; // RL10
         if (sync_take) begin
            beat_q <= 2'h1; // RL8
            frame_q <= 1'b1;
         end else if (beat_q == 2'(WORD_BEATS - 1)) begin
            beat_q <= 2'h0;
            frame_q <= 1'b0;
         end else begin
            beat_q <= beat_q + 2'h1;
         end
      end
   end

   // A sync cuts a partial word instead of closing it
   assign word_done = lck_rise && frame_q && !sync_take
                      && beat_q == 2'(WORD_BEATS - 1) && !link_reset;

   // Two-entry buffer; a stalled reader loses no word while it
   // is not full, overflow beyond two drops the newest
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 2'h0;
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         buf_q[0] <= '0;
         buf_q[1] <= '0;
      end else begin
         if (word_done && cnt_q != 2'h2) begin
            buf_q[wr_ptr_q] <= {sh_q[WORD_W-4:0], t2_q[2], t1_q[2],
                                t0_q[2]};
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (rx_valid && rx_ready) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_q + 2'((word_done && cnt_q != 2'h2) ? 1 : 0)
                  - 2'((rx_valid && rx_ready) ? 1 : 0);
      end
   end

   // Combinational view of the buffer head
   always_comb begin
      rx_valid = cnt_q != 2'h0;
      rx_word = buf_q[rd_ptr_q];
   end

   ////////////////////////////////////////////////////////////////
   // Receive lines: shift words out on link clock rising side
   always_ff @(posedge clk) begin
      if (rst || link_reset) begin
         txs_q <= '0;
         tbeat_q <= 2'h0;
         tx_ready <= 1'b0;
         {link_rx_bit2, link_rx_bit1, link_rx_bit0} <= 3'h0;
      end else begin
         tx_ready <= lck_rise && tbeat_q == 2'h0 && tx_valid;
         if (lck_rise) begin
            {link_rx_bit2, link_rx_bit1, link_rx_bit0} <=
               txs_q[WORD_W-1:WORD_W-3]; // RL11
            if (tbeat_q == 2'h0) begin
               txs_q <= tx_valid ? tx_word : '0;
            end else begin
               txs_q <= {txs_q[WORD_W-4:0], 3'h0};
            end
            tbeat_q <= (tbeat_q == 2'(WORD_BEATS - 1)) ? 2'h0
                       : tbeat_q + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Indicator configuration from nonvolatile words
   always_ff @(posedge clk) begin
      if (rst) begin
         led_ac_q <= 16'h0000;
         led_b_q <= 16'h0000;
      end else if (nvm_we) begin
         if (nvm_addr == NVM_LED_AC) led_ac_q <= nvm_data; // RL12
         if (nvm_addr == NVM_LED_B) led_b_q <= nvm_data; // RL12
      end
   end

   // Indicators, serial path, status outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         indicator_a <= 1'b0;
         indicator_b <= 1'b0;
         indicator_c <= 1'b0;
         serial_path_sel <= 1'b0;
         powered_down <= 1'b0;
         link_clock_out <= 1'b0;
         test_mode <= 1'b0;
      end else begin
         indicator_a <= led_eval(led_ac_q[3:0], link_up, activity,
                                 line_speed == SPD_1000); // RL12
         indicator_b <= led_eval(led_b_q[3:0], link_up, activity,
                                 line_speed == SPD_1000);
         indicator_c <= led_eval(led_ac_q[11:8], link_up, activity,
                                 line_speed == SPD_1000);
         serial_path_sel <= line_speed == SPD_1000; // RL15
         powered_down <= pd_q;
         link_clock_out <= lclk_q;
         if (ts_q[2] == ts_q[1]) test_mode <= ts_q[2];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checks
   property p_pd_clock_low;
      @(posedge clk) disable iff (rst) pd_q |=> ##1 !link_clock_out;
   endproperty
   a_pd_clock_low: assert property (p_pd_clock_low) // RL4
      else $error("link clock runs in power-down");

   property p_wake;
      @(posedge clk) disable iff (rst) link_reset |=> !pd_q;
   endproperty
   a_wake: assert property (p_wake) // RL7
      else $error("no wake on long reset");

   property p_reset_len;
      @(posedge clk) disable iff (rst)
         rcnt_q >= 32'(RST_CYCLES) |=> link_reset;
   endproperty
   a_reset_len: assert property (p_reset_len) // RL5
      else $error("long assertion not taken as reset");

   property p_sync_no_reset;
      @(posedge clk) disable iff (rst) rcnt_q < 32'(RST_CYCLES)
         |=> !link_reset;
   endproperty
   a_sync_no_reset: assert property (p_sync_no_reset) // RL8
      else $error("short pulse treated as reset");

   property p_count;
      @(posedge clk) disable iff (rst)
         rs_now && lck_rise && !pd_q && rcnt_q < 32'h0000_0010
         |=> rcnt_q == $past(rcnt_q) + 32'h0000_0001;
   endproperty
   a_count: assert property (p_count) // RL14
      else $error("reset counter missed an edge");

   property p_serial;
      @(posedge clk) disable iff (rst)
         line_speed == SPD_1000 |=> serial_path_sel;
   endproperty
   a_serial: assert property (p_serial) // RL15
      else $error("gigabit not on serial path");

   // At gigabit a clock phase lasts at most two core cycles
   property p_gig_rate;
      @(posedge clk) disable iff (rst)
         line_speed == SPD_1000 && $past(line_speed) == SPD_1000
         && !pd_q && !$past(pd_q) && !$past(rst) && $stable(lclk_q)
         |=> $changed(lclk_q);
   endproperty
   a_gig_rate: assert property (p_gig_rate) // RL1
      else $error("gigabit link clock phase too long");

   property p_led_load;
      @(posedge clk) disable iff (rst)
         nvm_we && nvm_addr == NVM_LED_B |=> led_b_q == $past(nvm_data);
   endproperty
   a_led_load: assert property (p_led_load) // RL12
      else $error("indicator word not loaded");
endmodule

//--- design/lpl_pkg.sv
package lpl_pkg;
   // Line speed encoding from the media side
   localparam logic [1:0] SPD_10 = 2'h0;
   localparam logic [1:0] SPD_100 = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // Core clock and link clock rates, kHz
   localparam int CLK_KHZ = 200_000;
   localparam int LCLK_1000_KHZ = 62_500;
   localparam int LCLK_100_KHZ = 50_000;
   localparam int LCLK_10_KHZ = 5_000;
   // Half periods in core cycles, rounded down, at least one
   function automatic int half_cyc(input int khz);
      int h;
      h = CLK_KHZ / (2 * khz);
      return (h < 1) ? 1 : h;
   endfunction
   localparam int HALF_1000 = half_cyc(LCLK_1000_KHZ);
   localparam int HALF_100 = half_cyc(LCLK_100_KHZ);
   localparam int HALF_10 = half_cyc(LCLK_10_KHZ);
   // Link word is three transfers of three bits
   localparam int WORD_BEATS = 3;
   localparam int WORD_W = 9;
   // Nonvolatile word addresses for indicator setup
   localparam logic [7:0] NVM_LED_AC = 8'h18;
   localparam logic [7:0] NVM_LED_B = 8'h17;
   // Indicator modes, low nibble of each field
   localparam logic [3:0] LED_OFF = 4'h0;
   localparam logic [3:0] LED_ON = 4'h1;
   localparam logic [3:0] LED_LINK = 4'h2;
   localparam logic [3:0] LED_ACT = 4'h3;
   localparam logic [3:0] LED_L1000 = 4'h4;
   // Minimum reset hold on the sync line, microseconds
   localparam int RST_HOLD_US = 500;
endpackage

//--- test/lpl_link_test.sv
`timescale 1ns/1ps
module lpl_link_test;
   import lpl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, power_down_req = 1'b0, link_up = 1'b0;
   logic activity = 1'b0, rx_ready = 1'b0, tx_valid = 1'b0, nvm_we = 1'b0;
   logic test_en = 1'b0;
   logic [1:0] line_speed = SPD_100;
   logic [8:0] tx_word = 9'h000;
   logic [7:0] nvm_addr = 8'h00;
   logic [15:0] nvm_data = 16'h0000;
   logic lco, rs, t2, t1, t0, r2, r1, r0, rx_valid, tx_ready, ia, ib, ic;
   logic link_reset, powered_down, serial_path_sel, test_mode, hit;
   logic [8:0] rx_word, w0, w1;
   int miscompares = 0, cmp_count = 0, n, i;
   logic [31:0] seed = 32'h0000_4A17;
   always #2.5 clk = ~clk;
   lpl_link dut (.clk(clk), .rst(rst), .line_speed(line_speed),
      .power_down_req(power_down_req), .link_up(link_up),
      .activity(activity), .link_clock_out(lco), .reset_sync_line(rs),
      .link_tx_bit2(t2), .link_tx_bit1(t1), .link_tx_bit0(t0),
      .link_rx_bit2(r2), .link_rx_bit1(r1), .link_rx_bit0(r0),
      .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
      .indicator_a(ia), .indicator_b(ib), .indicator_c(ic),
      .link_reset(link_reset), .powered_down(powered_down),
      .serial_path_sel(serial_path_sel), .test_en(test_en),
      .test_mode(test_mode));
   lpl_mac_model mac (.link_clock_out(lco), .link_rx_bit2(r2),
      .link_rx_bit1(r1), .link_rx_bit0(r0), .reset_sync_line(rs),
      .link_tx_bit2(t2), .link_tx_bit1(t1), .link_tx_bit0(t0));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic led_exp(input logic [3:0] m);
      case (m)
         LED_ON: return 1'b1;
         LED_LINK: return link_up;
         LED_ACT: return link_up & activity;
         LED_L1000: return link_up & (line_speed == SPD_1000);
         default: return 1'b0;
      endcase
   endfunction
   // Core cycles in five link periods at a given line speed
   function automatic int lclk_cyc(input logic [1:0] s);
      return 5 * CLK_KHZ / (s == SPD_1000 ? LCLK_1000_KHZ :
                            s == SPD_100 ? LCLK_100_KHZ : LCLK_10_KHZ);
   endfunction
   task automatic check(input string nm, input logic [15:0] s, e);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Cycles up to the next link clock rise, 400 if none comes
   task automatic wait_rise(output int k);
      logic p;
      k = 0;
      p = lco;
      while (k < 400 && !(p === 1'b0 && lco === 1'b1)) begin
         p = lco;
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic pop(input logic [8:0] e);
      for (n = 0; n < 100 && rx_valid !== 1'b1; n++) @(posedge clk);
      @(negedge clk);
      check("rx_word", {7'h0, rx_word}, {7'h0, e});
      rx_ready = 1'b1;
      @(negedge clk);
      rx_ready = 1'b0;
   endtask
   task automatic nvm(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      {nvm_we, nvm_addr, nvm_data} = {1'b1, a, d};
      @(negedge clk);
      nvm_we = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   initial begin
      #100_000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      // Link clock rate per line speed, five whole periods summed
      for (int j = 0; j < 3; j++) begin
         @(negedge clk);
         line_speed = j == 0 ? SPD_10 : j == 1 ? SPD_100 : SPD_1000;
         wait_rise(n);
         i = 0;
         repeat (5) begin
            wait_rise(n);
            i += n;
         end
         check("period", 16'(i), 16'(lclk_cyc(line_speed)));
         check("serial", {15'h0, serial_path_sel},
               {15'h0, line_speed == SPD_1000});
      end
      @(negedge clk);
      line_speed = SPD_100;
      // Two stalled words fill the buffer, the third is refused
      seed = xs(seed); w0 = seed[8:0];
      seed = xs(seed); w1 = seed[8:0];
      mac.send_word(w0);
      mac.send_word(w1);
      mac.send_word(~w1);
      repeat (20) @(negedge clk);
      check("sync_reset", {15'h0, link_reset}, 16'h0000);
      pop(w0);
      pop(w1);
      check("dropped", {15'h0, rx_valid}, 16'h0000);
      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         mac.send_word(i == 0 ? 9'h1ff : i == 1 ? 9'h000 : seed[8:0]);
         pop(i == 0 ? 9'h1ff : i == 1 ? 9'h000 : seed[8:0]);
      end
      // Words outward, found whole on the receive lines
      for (i = 0; i < 3; i++) begin
         seed = xs(seed);
         @(negedge clk);
         {tx_valid, tx_word} = {1'b1, seed[8:0]};
         for (n = 0; n < 200 && tx_ready !== 1'b1; n++) @(negedge clk);
         @(negedge clk);
         tx_valid = 1'b0;
         hit = 1'b0;
         repeat (200) @(posedge clk) hit |= (mac.seen_q === seed[8:0]);
         check("rx_lines", {15'h0, hit}, 16'h0001);
      end
      // Every indicator mode on words 18h and 17h
      for (i = 0; i < 5; i++) begin
         seed = xs(seed);
         @(negedge clk);
         {link_up, activity} = seed[1:0];
         nvm(NVM_LED_AC, {4'h0, 4'(i), 4'h0, 4'(4 - i)});
         nvm(NVM_LED_B, {12'h000, 4'(i)});
         check("ind_a", {15'h0, ia}, {15'h0, led_exp(4'(4 - i))});
         check("ind_c", {15'h0, ic}, {15'h0, led_exp(4'(i))});
         check("ind_b", {15'h0, ib}, {15'h0, led_exp(4'(i))});
      end
      test_en = 1'b1;
      repeat (6) @(negedge clk);
      check("test_mode", {15'h0, test_mode}, 16'h0001);
      test_en = 1'b0;
      // Long hold is a reset request
      fork
         mac.hold_reset(400);
         begin
            #350;
            check("link_reset", {15'h0, link_reset}, 16'h0001);
         end
      join
      repeat (40) @(negedge clk);
      check("reset_end", {15'h0, link_reset}, 16'h0000);
      // Power-down stops the clock, a long hold wakes the device
      power_down_req = 1'b1;
      repeat (20) @(negedge clk);
      check("pd", {15'h0, powered_down}, 16'h0001);
      wait_rise(n);
      check("clk_stop", 16'(n), 16'h0190);
      check("clk_low", {15'h0, lco}, 16'h0000);
      @(negedge clk);
      power_down_req = 1'b0;
      mac.hold_reset(400);
      repeat (40) @(negedge clk);
      check("wake", {15'h0, powered_down}, 16'h0000);
      final_report();
   end
endmodule

//--- test/lpl_mac_model.sv
`timescale 1ns/1ps
// Far-side controller on the parallel link
module lpl_mac_model (
   // Link pins
   input wire logic link_clock_out,
   input wire logic link_rx_bit2,
   input wire logic link_rx_bit1,
   input wire logic link_rx_bit0,
   output logic reset_sync_line,
   output logic link_tx_bit2,
   output logic link_tx_bit1,
   output logic link_tx_bit0
);
   logic [8:0] seen_q;
   initial begin
      reset_sync_line = 1'b0;
      {link_tx_bit2, link_tx_bit1, link_tx_bit0} = 3'h0;
      seen_q = 9'h000;
   end
   // Receive beats on falls, half a cycle after the device moved them
   always @(negedge link_clock_out) begin
      seen_q <= {seen_q[5:0], link_rx_bit2, link_rx_bit1,
                 link_rx_bit0};
   end
   // Drive just after the rise so a beat stands a whole link cycle
   task automatic beat(input logic s, input logic [2:0] b);
      @(posedge link_clock_out);
      #1;
      reset_sync_line = s;
      {link_tx_bit2, link_tx_bit1, link_tx_bit0} = b;
   endtask
   // Sync pulse, three beats high group first, then inverted idle
   task automatic send_word(input logic [8:0] w);
      beat(1'b1, ~w[8:6]);
      beat(1'b0, w[8:6]);
      beat(1'b0, w[5:3]);
      beat(1'b0, w[2:0]);
      beat(1'b0, ~w[2:0]);
   endtask
   // Timed hold, since the link clock stops in power-down; far
   // shorter than the real minimum so the run stays brief
   task automatic hold_reset(input int ns);
      reset_sync_line = 1'b1;
      #(ns);
      reset_sync_line = 1'b0;
   endtask
endmodule
